// [design/ncd_consts.svh]
// How it works
// - Bucket write: index low six, value bit10
// - Group frames hashed into 64-entry bucket table
// - Threshold command loads [12:2], clears [1:0]
// - Byte count above threshold sets early flag
// - Early upload waits for threshold bytes
// - Filter command loads five accept bits
// - Filter bits add; promiscuous overrides other four
// - Halt command stops descriptor link fetching
// - Host waits for pending flag clear
// - Release command resumes descriptor link fetching
// - Nonzero poll interval auto-releases busy descriptor
// - Clear command drops selected status bits
// - Clearing inactive indication changes nothing
// - Software command sets request bit, interrupts
// - Countdown reaching zero sets request bit
// - Indication mask hides sources; system reset clears
// - Interrupt mask gates host; adapter reset clears
// - Coax converter off until power-on command
// - Bank select picks bank 0-7, default 0
// - Counters halted until run; halt keeps values
`ifndef NCD_CONSTS_SVH
`define NCD_CONSTS_SVH
// Register byte offsets
`define NCD_OFF_CMD 8'h00
`define NCD_OFF_DMA 8'h04
`define NCD_OFF_POLL 8'h08
`define NCD_OFF_CFG 8'h0C
`define NCD_OFF_THR 8'h10
`define NCD_OFF_MASK 8'h14
`define NCD_OFF_HLO 8'h18
`define NCD_OFF_HHI 8'h1C
// Field positions
`define NCD_BIT_HASH_VAL 10
`define NCD_BIT_GROUP 40
`define NCD_BIT_PEND 12
`define NCD_BIT_EARLY 5
`define NCD_BIT_REQ 6
`define NCD_BIT_LINK 1
`define NCD_BIT_DN 9
`define NCD_BIT_UP 10
`define NCD_BIT_PROMISC 3
// Status bits that the clear command may touch
`define NCD_ACK_MASK 11'h663
// Reset values
`define NCD_RST_BANK 3'h0
`define NCD_RST_POLL 8'h00
`endif

// [design/ncd_pkg.sv]
package ncd_pkg;
   // Command codes in the upper five bits of the command word
   typedef enum logic [4:0] {
      NCD_BANK = 5'b00001, NCD_COAX_ON = 5'b00010, NCD_UPL = 5'b00110,
      NCD_REQ = 5'b01100, NCD_ACK = 5'b01101, NCD_INT_EN = 5'b01110,
      NCD_IND_EN = 5'b01111, NCD_FILT = 5'b10000, NCD_THR = 5'b10001,
      NCD_STAT_ON = 5'b10101, NCD_STAT_OFF = 5'b10110,
      NCD_COAX_OFF = 5'b10111, NCD_HASH = 5'b11001
   } ncd_cmd_type;
   // Receive side view of the current frame
   typedef struct packed {
      logic addr_valid;
      logic [47:0] dest;
      logic station_hit;
      logic in_frame;
      logic [12:0] byte_count;
   } ncd_rx_type;
   // Event pulses from the rest of the adapter
   typedef struct packed {
      logic link;
      logic dn_done;
      logic up_done;
      logic countdown_zero;
   } ncd_evt_type;
   // Upload descriptor fetcher status
   typedef struct packed {
      logic idle;
      logic busy_stall;
      logic poll_ack;
      logic poll_bit;
   } ncd_fetch_type;
   // Whole state of the decoder
   typedef struct packed {
      logic [63:0] hash;
      logic [12:0] thresh;
      logic [4:0] filter;
      logic halt;
      logic pending;
      logic [10:0] status;
      logic [10:0] ind_en;
      logic [10:0] int_en;
      logic coax_on;
      logic [2:0] bank;
      logic stats_on;
      logic early_en;
      logic early_seen;
      logic [7:0] poll;
      logic [7:0] poll_cnt;
      logic poll_rd;
      logic desc_release;
      logic rx_decide;
      logic rx_accept;
      logic upload_ok;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic ready;
   } ncd_state_type;
endpackage

// [design/ncd_top.sv]
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ncd_consts.svh"
module ncd_top (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_adapter_reset,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire ncd_pkg::ncd_rx_type i_rx,
   input wire ncd_pkg::ncd_evt_type i_evt,
   input wire ncd_pkg::ncd_fetch_type i_fetch,
   output logic o_rx_decide,
   output logic o_rx_accept,
   output logic o_upload_ok,
   output logic o_fetch_halt,
   output logic o_poll_read,
   output logic o_desc_release,
   output logic o_irq,
   output logic o_coax_on,
   output logic [2:0] o_bank,
   output logic o_stats_run
);
   ncd_pkg::ncd_state_type s_reg;
   ncd_pkg::ncd_state_type s_next;
   logic rst_meta_reg;
   logic rst_n;
   logic cmd_v;
   logic halt_cmd;
   logic [15:0] cmd;
   logic [10:0] set_v;
   logic [10:0] clr_v;
   logic [10:0] eff_v;
   logic [5:0] crc_idx;

   // Ethernet CRC over the destination, octet [47:40] first, LSB first
   function automatic logic [5:0] crc_low6(input logic [47:0] d);
      logic [31:0] c;
      logic fb;
      c = 32'hFFFFFFFF;
      for (int i = 0; i < 48; i++) begin
         fb = c[0] ^ d[47 - 8 * (i / 8) - 7 + (i % 8)];
         c = {1'b0, c[31:1]} ^ (fb ? 32'hEDB88320 : 32'h00000000);
      end
      return c[5:0];
   endfunction

   // Register read mux; reserved bits and unmapped words read zero
   function automatic logic [31:0] rd_mux(input ncd_pkg::ncd_state_type st,
                                         input logic [7:0] a);
      logic [31:0] r;
      r = 32'h00000000;
      case (a)
         `NCD_OFF_CMD: begin
            r[10:0] = st.status & {st.ind_en[10:1], 1'b1};
            r[`NCD_BIT_PEND] = st.pending;
         end
         `NCD_OFF_DMA: r[0] = st.early_en;
         `NCD_OFF_POLL: r[7:0] = st.poll;
         `NCD_OFF_CFG: r[15:0] = {1'b0, st.halt, st.stats_on, st.coax_on, 1'b0,
                                  st.bank, 3'h0, st.filter};
         `NCD_OFF_THR: r[12:0] = st.thresh;
         `NCD_OFF_MASK: r = {5'h00, st.int_en, 5'h00, st.ind_en};
         `NCD_OFF_HLO: r = st.hash[31:0];
         `NCD_OFF_HHI: r = st.hash[63:32];
         default: r = 32'h00000000;
      endcase
      return r;
   endfunction

   // Reset is asserted at once and released through two flops
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // A command takes effect in the data phase of its write
   assign cmd_v = s_reg.wr_pend && (s_reg.wr_addr == `NCD_OFF_CMD);
   assign cmd = i_hwdata[15:0];
   assign halt_cmd = cmd_v && (cmd[15:11] == ncd_pkg::NCD_UPL) && (cmd[4:0] == 5'h00);
   assign crc_idx = crc_low6(i_rx.dest);

   // Next state: bus, command decode, events, filter, fetcher
   always_comb begin
      s_next = s_reg;
      s_next.ready = 1'b1;
      s_next.desc_release = 1'b0;
      s_next.poll_rd = 1'b0;
      s_next.rx_decide = 1'b0;
      set_v = 11'h000;
      clr_v = 11'h000;
      eff_v = 11'h000;
      // Data phase of a write
      if (s_reg.wr_pend && s_reg.wr_addr == `NCD_OFF_DMA) begin
         s_next.early_en = i_hwdata[0];
      end
      if (s_reg.wr_pend && s_reg.wr_addr == `NCD_OFF_POLL) begin
         s_next.poll = i_hwdata[7:0];
      end
      if (cmd_v) begin
         case (cmd[15:11])
            ncd_pkg::NCD_HASH: begin
               s_next.hash[cmd[5:0]] = cmd[`NCD_BIT_HASH_VAL];
            end
            ncd_pkg::NCD_THR: begin
               s_next.thresh = {cmd[10:0], 2'b00};
            end
            ncd_pkg::NCD_FILT: begin
               s_next.filter = cmd[4:0];
            end
            ncd_pkg::NCD_UPL: begin
               // Only the upload pair; the download pair shares the prefix
               if (cmd[4:1] == 4'h0) begin
                  if (!cmd[0]) begin
                     s_next.halt = 1'b1;
                     s_next.pending = 1'b1;
                  end else begin
                     s_next.halt = 1'b0;
                  end
               end
            end
            ncd_pkg::NCD_ACK: clr_v = cmd[10:0] & `NCD_ACK_MASK;
            ncd_pkg::NCD_REQ: set_v[`NCD_BIT_REQ] = 1'b1;
            ncd_pkg::NCD_IND_EN: s_next.ind_en = {cmd[10:1], 1'b0};
            ncd_pkg::NCD_INT_EN: s_next.int_en = {cmd[10:1], 1'b0};
            ncd_pkg::NCD_COAX_ON: s_next.coax_on = 1'b1;
            ncd_pkg::NCD_COAX_OFF: s_next.coax_on = 1'b0;
            ncd_pkg::NCD_BANK: begin
               if (cmd[10:3] == 8'h00) begin
                  s_next.bank = cmd[2:0];
               end
            end
            ncd_pkg::NCD_STAT_ON: s_next.stats_on = 1'b1;
            ncd_pkg::NCD_STAT_OFF: s_next.stats_on = 1'b0;
            default: s_next.hash = s_reg.hash;
         endcase
      end
      // Adapter reset clears only the interrupt mask
      if (i_adapter_reset) begin
         s_next.int_en = 11'h000;
      end
      // Early indication fires once per frame, re-armed between frames
      if (!i_rx.in_frame) begin
         s_next.early_seen = 1'b0;
      end else if (!s_reg.early_seen && i_rx.byte_count > s_reg.thresh) begin
         set_v[`NCD_BIT_EARLY] = 1'b1;
         s_next.early_seen = 1'b1;
      end
      set_v[`NCD_BIT_LINK] = i_evt.link;
      set_v[`NCD_BIT_DN] = i_evt.dn_done;
      set_v[`NCD_BIT_UP] = i_evt.up_done;
      set_v[`NCD_BIT_REQ] = set_v[`NCD_BIT_REQ] | i_evt.countdown_zero;
      // Masked sources never reach status; a set beats a clear
      eff_v = set_v & s_reg.ind_en;
      s_next.status[10:1] = (s_reg.status[10:1] & ~clr_v[10:1]) | eff_v[10:1];
      s_next.status[0] = (s_reg.status[0] & ~clr_v[0]) | (|(eff_v & s_reg.int_en));
      // Pending drops once the fetcher confirms it is parked; a fresh halt wins
      if (s_reg.pending && s_reg.halt && i_fetch.idle && !halt_cmd) begin
         s_next.pending = 1'b0;
      end
      // Automatic release: re-read the busy descriptor every poll interval
      if (s_reg.poll != 8'h00 && i_fetch.busy_stall && !s_reg.halt) begin
         if (s_reg.poll_cnt >= s_reg.poll) begin
            s_next.poll_cnt = 8'h00;
            s_next.poll_rd = 1'b1;
         end else begin
            s_next.poll_cnt = s_reg.poll_cnt + 8'h01;
         end
         if (i_fetch.poll_ack && !i_fetch.poll_bit) begin
            s_next.desc_release = 1'b1;
         end
      end else begin
         s_next.poll_cnt = 8'h00;
      end
      // Address filter; promiscuous simply ORs in over the rest
      if (i_rx.addr_valid) begin
         s_next.rx_decide = 1'b1;
         s_next.rx_accept = s_reg.filter[`NCD_BIT_PROMISC]
            | (s_reg.filter[0] & i_rx.station_hit)
            | (s_reg.filter[1] & i_rx.dest[`NCD_BIT_GROUP])
            | (s_reg.filter[2] & (&i_rx.dest))
            | (s_reg.filter[4] & i_rx.dest[`NCD_BIT_GROUP]
               & s_reg.hash[crc_idx]);
      end
      s_next.upload_ok = i_rx.in_frame
         & (!s_reg.early_en | (i_rx.byte_count >= s_reg.thresh));
      // Address phase; zero wait states, read data registered here
      if (i_hready) begin
         s_next.wr_pend = i_hsel && i_htrans[1] && i_hwrite;
         s_next.wr_addr = i_haddr[7:0];
         s_next.rdata = (i_hsel && i_htrans[1] && !i_hwrite) ?
                        rd_mux(s_reg, i_haddr[7:0]) : 32'h00000000;
      end
   end

   // State register
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.bank <= `NCD_RST_BANK;
         s_reg.poll <= `NCD_RST_POLL;
         s_reg.ready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state flops, except o_hresp tied low
   assign o_hrdata = s_reg.rdata;
   assign o_hreadyout = s_reg.ready;
   assign o_hresp = 1'b0;
   assign o_rx_decide = s_reg.rx_decide;
   assign o_rx_accept = s_reg.rx_accept;
   assign o_upload_ok = s_reg.upload_ok;
   assign o_fetch_halt = s_reg.halt;
   assign o_poll_read = s_reg.poll_rd;
   assign o_desc_release = s_reg.desc_release;
   assign o_irq = s_reg.status[0];
   assign o_coax_on = s_reg.coax_on;
   assign o_bank = s_reg.bank;
   assign o_stats_run = s_reg.stats_on;

   // Bucket write lands in the addressed entry
   property p_hash_write;
      @(posedge i_mclk) disable iff (!rst_n)
      (cmd_v && cmd[15:11] == ncd_pkg::NCD_HASH)
      |=> s_reg.hash[$past(cmd[5:0])] == $past(cmd[10]);
   endproperty
   a_hash_write: assert property (p_hash_write) else $error("bucket write lost");

   property p_thresh;
      @(posedge i_mclk) disable iff (!rst_n)
      (cmd_v && cmd[15:11] == ncd_pkg::NCD_THR)
      |=> s_reg.thresh == {$past(cmd[10:0]), 2'b00};
   endproperty
   a_thresh: assert property (p_thresh) else $error("threshold load wrong");

   property p_promisc;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_rx.addr_valid && s_reg.filter[3]) |=> (o_rx_decide && o_rx_accept);
   endproperty
   a_promisc: assert property (p_promisc) else $error("promiscuous frame refused");

   property p_halt;
      @(posedge i_mclk) disable iff (!rst_n)
      (cmd_v && cmd == 16'h3000) |=> (o_fetch_halt && s_reg.pending);
   endproperty
   a_halt: assert property (p_halt) else $error("halt not taken");

   property p_pending_clear;
      @(posedge i_mclk) disable iff (!rst_n)
      (s_reg.pending && s_reg.halt && i_fetch.idle && !halt_cmd) |=> !s_reg.pending;
   endproperty
   a_pending_clear: assert property (p_pending_clear) else $error("pending stuck");

   property p_masked_ind;
      @(posedge i_mclk) disable iff (!rst_n)
      $rose(s_reg.status[6]) |-> $past(s_reg.ind_en[6]);
   endproperty
   a_masked_ind: assert property (p_masked_ind) else $error("masked request shown");

   property p_irq_cause;
      @(posedge i_mclk) disable iff (!rst_n)
      $rose(o_irq) |-> $past(|s_reg.int_en);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without enable");

   property p_coax;
      @(posedge i_mclk) disable iff (!rst_n)
      $rose(o_coax_on) |-> $past(cmd_v && cmd[15:11] == ncd_pkg::NCD_COAX_ON);
   endproperty
   a_coax: assert property (p_coax) else $error("converter on unasked");

   property p_early;
      @(posedge i_mclk) disable iff (!rst_n)
      (s_reg.early_en && i_rx.byte_count < s_reg.thresh) |=> !o_upload_ok;
   endproperty
   a_early: assert property (p_early) else $error("early upload too soon");

   // Filter command replaces all five accept bits
   property p_filter_load;
      @(posedge i_mclk) disable iff (!rst_n)
      (cmd_v && cmd[15:11] == ncd_pkg::NCD_FILT)
      |=> s_reg.filter == $past(cmd[4:0]);
   endproperty
   a_filter_load: assert property (p_filter_load) else $error("filter load wrong");

   // Release lifts the halt at once
   property p_release;
      @(posedge i_mclk) disable iff (!rst_n)
      (cmd_v && cmd == 16'h3001)
      |=> !o_fetch_halt;
   endproperty
   a_release: assert property (p_release) else $error("halt not lifted");

   // Clearing the link bit works unless a new link event lands with it
   property p_ack_link;
      @(posedge i_mclk) disable iff (!rst_n)
      (cmd_v && cmd[15:11] == ncd_pkg::NCD_ACK && cmd[`NCD_BIT_LINK] && !i_evt.link)
      |=> !s_reg.status[`NCD_BIT_LINK];
   endproperty
   a_ack_link: assert property (p_ack_link) else $error("link bit not cleared");

   // Software request shows when its indication is enabled
   property p_req_set;
      @(posedge i_mclk) disable iff (!rst_n)
      (cmd_v && cmd[15:11] == ncd_pkg::NCD_REQ && s_reg.ind_en[`NCD_BIT_REQ])
      |=> s_reg.status[`NCD_BIT_REQ];
   endproperty
   a_req_set: assert property (p_req_set) else $error("request bit not set");

   // Countdown expiry raises the same request bit
   property p_cd_set;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_evt.countdown_zero && s_reg.ind_en[`NCD_BIT_REQ])
      |=> s_reg.status[`NCD_BIT_REQ];
   endproperty
   a_cd_set: assert property (p_cd_set) else $error("countdown request lost");

   // A well formed bank select lands in the bank output
   property p_bank;
      @(posedge i_mclk) disable iff (!rst_n)
      (cmd_v && cmd[15:11] == ncd_pkg::NCD_BANK && cmd[10:3] == 8'h00)
      |=> o_bank == $past(cmd[2:0]);
   endproperty
   a_bank: assert property (p_bank) else $error("bank not selected");

   // Counters only start on the run command
   property p_stats;
      @(posedge i_mclk) disable iff (!rst_n)
      $rose(o_stats_run)
      |-> $past(cmd_v && cmd[15:11] == ncd_pkg::NCD_STAT_ON);
   endproperty
   a_stats: assert property (p_stats) else $error("counters started unasked");

   // First byte count above the threshold raises the early flag
   property p_early_set;
      @(posedge i_mclk) disable iff (!rst_n)
      (i_rx.in_frame && !s_reg.early_seen && i_rx.byte_count > s_reg.thresh
         && s_reg.ind_en[`NCD_BIT_EARLY])
      |=> s_reg.status[`NCD_BIT_EARLY];
   endproperty
   a_early_set: assert property (p_early_set) else $error("early flag not set");

   // Adapter reset empties the interrupt mask
   property p_mask_reset;
      @(posedge i_mclk) disable iff (!rst_n)
      i_adapter_reset
      |=> s_reg.int_en == 11'h000;
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("interrupt mask kept");

   // Indication mask takes the parameter with bit 0 dropped
   property p_ind_load;
      @(posedge i_mclk) disable iff (!rst_n)
      (cmd_v && cmd[15:11] == ncd_pkg::NCD_IND_EN)
      |=> s_reg.ind_en == {$past(cmd[10:1]), 1'b0};
   endproperty
   a_ind_load: assert property (p_ind_load) else $error("mask load wrong");
endmodule
`default_nettype wire

// [test/ncd_fetch_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Upload descriptor fetcher stand-in: parks late after a halt, re-reads a busy word
module ncd_fetch_model (
   input wire logic i_clk,
   input wire logic i_halt,
   input wire logic i_poll_read,
   input wire logic i_busy,
   input wire logic [3:0] i_park_dly,
   input wire logic [3:0] i_busy_reads,
   output var ncd_pkg::ncd_fetch_type o_fetch
);
   logic [3:0] park_cnt;
   logic [3:0] reads;
   initial o_fetch = '0;
   initial park_cnt = 4'h0;
   initial reads = 4'h0;
   // Slow parking keeps the pending flag visible; polled bit flips when not read
   always @(posedge i_clk) begin
      park_cnt <= i_halt ? park_cnt + {3'h0, park_cnt != 4'hF} : 4'h0;
      o_fetch.idle <= i_halt && park_cnt >= i_park_dly;
      o_fetch.busy_stall <= i_busy && !i_halt;
      o_fetch.poll_ack <= i_poll_read;
      o_fetch.poll_bit <= i_poll_read ? reads < i_busy_reads : ~o_fetch.poll_bit;
      reads <= !i_busy ? 4'h0 : reads + {3'h0, i_poll_read};
   end
endmodule
`default_nettype wire

// [test/tb_nic_rx_intr_misc_command_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_nic_rx_intr_misc_command_decoder;
   typedef struct packed {
      logic [3:0] ev;
      logic [15:0] cmd;
      logic [7:0] a;
      logic [31:0] m;
      logic [31:0] e;
   } ncd_row_type;
   typedef struct packed {
      logic [4:0] f;
      logic hit;
      logic [47:0] d;
      logic acc;
   } ncd_rxc_type;
   localparam logic [31:0] st = 32'h17FF;
   localparam logic [47:0] mc = 48'h01005E0000A7;
   logic i_mclk, i_rst_b, i_adapter_reset, i_hwrite, busy, rel;
   logic [1:0] i_htrans;
   logic [31:0] i_haddr, i_hwdata, o_hrdata, q;
   logic o_hreadyout, o_rx_decide, o_rx_accept, o_upload_ok, o_fetch_halt, o_poll_read;
   logic o_desc_release, o_irq, o_coax_on, o_stats_run, o_hresp;
   logic [2:0] o_bank;
   logic [5:0] hidx;
   ncd_pkg::ncd_rx_type i_rx;
   ncd_pkg::ncd_evt_type i_evt;
   ncd_pkg::ncd_fetch_type fetch;
   int miscompares, n_tests, cycles, reads;
   // Commands and events with the register view that should follow
   ncd_row_type rows [$] = '{
      '{4'h0, 16'h0805, 8'h0C, 32'h700, 32'h500},
      '{4'h0, 16'h0807, 8'h0C, 32'h700, 32'h700},
      '{4'h0, 16'h1000, 8'h0C, 32'h1000, 32'h1000},
      '{4'h0, 16'hB800, 8'h0C, 32'h1000, 32'h0},
      '{4'h0, 16'hA800, 8'h0C, 32'h2000, 32'h2000},
      '{4'h0, 16'hB000, 8'h0C, 32'h2000, 32'h0},
      '{4'h0, 16'h801F, 8'h0C, 32'h1F, 32'h1F},
      '{4'h0, 16'hF800, 8'h0C, 32'h7FFF, 32'h71F},
      '{4'h0, 16'h8FFF, 8'h10, 32'h1FFF, 32'h1FFC},
      '{4'h0, 16'h8805, 8'h10, 32'h1FFF, 32'h14},
      '{4'h0, 16'hCC3F, 8'h1C, 32'h80000000, 32'h80000000},
      '{4'h0, 16'hCC00, 8'h18, 32'h1, 32'h1},
      '{4'h0, 16'hC83F, 8'h1C, 32'h80000000, 32'h0},
      '{4'h0, 16'h7FFF, 8'h14, 32'h7FF, 32'h7FE},
      '{4'h0, 16'h77FF, 8'h14, 32'h7FF0000, 32'h7FE0000},
      '{4'h8, 16'h0, 8'h00, st, 32'h3},
      '{4'h0, 16'h6802, 8'h00, st, 32'h1},
      '{4'h0, 16'h6801, 8'h00, st, 32'h0},
      '{4'h0, 16'h6000, 8'h00, st, 32'h41},
      '{4'h0, 16'h6820, 8'h00, st, 32'h41},
      '{4'h0, 16'h6841, 8'h00, st, 32'h0},
      '{4'h1, 16'h0, 8'h00, st, 32'h41},
      '{4'h0, 16'h6841, 8'h00, st, 32'h0},
      '{4'h2, 16'h0, 8'h00, st, 32'h401},
      '{4'h0, 16'h6C01, 8'h00, st, 32'h0},
      '{4'h0, 16'h7000, 8'h14, 32'h7FF0000, 32'h0},
      '{4'h4, 16'h0, 8'h00, st, 32'h200},
      '{4'h0, 16'h6A00, 8'h00, st, 32'h0},
      '{4'h0, 16'h7800, 8'h14, 32'h7FF, 32'h0},
      '{4'h8, 16'h0, 8'h00, st, 32'h0},
      '{4'h0, 16'h7FFF, 8'h14, 32'h7FF, 32'h7FE}
   };
   // Filter settings against frames: unicast, multicast, broadcast
   ncd_rxc_type rxc [$] = '{
      '{5'h01, 1'b1, 48'h020000000001, 1'b1},
      '{5'h01, 1'b0, 48'h020000000001, 1'b0},
      '{5'h02, 1'b0, mc, 1'b1},
      '{5'h02, 1'b0, 48'hFFFFFFFFFFFF, 1'b1},
      '{5'h04, 1'b0, 48'hFFFFFFFFFFFF, 1'b1},
      '{5'h04, 1'b0, mc, 1'b0},
      '{5'h03, 1'b1, 48'h020000000001, 1'b1},
      '{5'h03, 1'b0, mc, 1'b1},
      '{5'h08, 1'b0, 48'h020000000001, 1'b1},
      '{5'h00, 1'b1, 48'h020000000001, 1'b0}
   };
   ncd_top dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_adapter_reset(i_adapter_reset),
      .i_hsel(1'b1), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
      .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
      .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_rx(i_rx), .i_evt(i_evt), .i_fetch(fetch),
      .o_rx_decide(o_rx_decide), .o_rx_accept(o_rx_accept), .o_upload_ok(o_upload_ok),
      .o_fetch_halt(o_fetch_halt), .o_poll_read(o_poll_read), .o_desc_release(o_desc_release),
      .o_irq(o_irq), .o_coax_on(o_coax_on), .o_bank(o_bank), .o_stats_run(o_stats_run));
   ncd_fetch_model fm (.i_clk(i_mclk), .i_halt(o_fetch_halt), .i_poll_read(o_poll_read),
      .i_busy(busy), .i_park_dly(4'h5), .i_busy_reads(4'h2), .o_fetch(fetch));
   // Free-running 25 MHz clock
   always #20 i_mclk = ~i_mclk;
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Hang guard, above the converter settling wait plus the bus traffic
   always @(posedge i_mclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Single AHB transfer; each phase is held until hready is seen high
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_htrans <= 2'h2;
      i_haddr <= {24'h0, a};
      i_hwrite <= wr;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      q = o_hrdata;
   endtask
   task automatic cmd(input logic [15:0] c);
      bus(1'b1, 8'h00, {16'h0, c});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   task automatic pulse_evt(input logic [3:0] e);
      @(posedge i_mclk);
      i_evt <= ncd_pkg::ncd_evt_type'(e);
      @(posedge i_mclk);
      i_evt <= '0;
   endtask
   task automatic set_cnt(input logic [12:0] n);
      @(posedge i_mclk);
      i_rx.byte_count <= n;
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
   endtask
   // One address decision: decide pulses once, accept carries the verdict
   task automatic rx(input logic [47:0] d, input logic hit, input logic acc);
      @(posedge i_mclk);
      i_rx.addr_valid <= 1'b1;
      i_rx.dest <= d;
      i_rx.station_hit <= hit;
      @(posedge i_mclk);
      i_rx.addr_valid <= 1'b0;
      @(negedge i_mclk);
      chk({31'h0, o_rx_decide}, 32'h1);
      chk({31'h0, o_rx_accept}, {31'h0, acc});
   endtask
   // Bucket index: reflected CRC, first octet first, low bit of each octet first
   function automatic logic [5:0] crc_idx(input logic [47:0] d);
      logic [31:0] c;
      c = 32'hFFFFFFFF;
      for (int k = 0; k < 48; k++) begin
         c = (c >> 1) ^ ((c[0] ^ d[40 - 8 * (k / 8) + k % 8]) ? 32'hEDB88320 : 32'h0);
      end
      return c[5:0];
   endfunction
   initial begin
      {i_mclk, i_rst_b, i_adapter_reset, i_hwrite, busy, i_htrans} = '0;
      {i_haddr, i_hwdata} = '0;
      i_rx = '0;
      i_evt = '0;
      {miscompares, n_tests, cycles} = '0;
      repeat (2) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_mclk);
      rd(8'h0C, 32'h7FFF, 32'h0);
      rd(8'h14, 32'h7FF07FF, 32'h0);
      rd(8'h40, 32'hFFFFFFFF, 32'h0);
      chk({31'h0, o_hresp}, 32'h0);
      foreach (rows[i]) begin
         if (rows[i].ev != 4'h0) pulse_evt(rows[i].ev);
         if (rows[i].cmd != 16'h0) cmd(rows[i].cmd);
         rd(rows[i].a, rows[i].m, rows[i].e);
         if (rows[i].a == 8'h00) chk({31'h0, o_irq}, {31'h0, rows[i].e[0]});
         // Output pins must agree with the configuration view
         if (rows[i].a == 8'h0C) begin
            chk({18'h0, o_stats_run, o_coax_on, 1'b0, o_bank, 8'h0} & rows[i].m,
                rows[i].e & 32'h3700);
         end
      end
      cmd(16'h77FF);
      @(posedge i_mclk);
      i_adapter_reset <= 1'b1;
      @(posedge i_mclk);
      i_adapter_reset <= 1'b0;
      rd(8'h14, 32'h7FF07FF, 32'h7FE);
      // Converter was switched off above; let it settle 800 us before frames
      repeat (20000) @(posedge i_mclk);
      foreach (rxc[i]) begin
         cmd({5'h10, 6'h0, rxc[i].f});
         rx(rxc[i].d, rxc[i].hit, rxc[i].acc);
      end
      hidx = crc_idx(mc);
      cmd(16'h8010);
      cmd({5'h19, 1'b1, 4'h0, hidx});
      rx(mc, 1'b0, 1'b1);
      cmd({5'h19, 1'b0, 4'h0, hidx});
      rx(mc, 1'b0, 1'b0);
      // Threshold of 4 bytes: the indication needs strictly more
      cmd(16'h8801);
      i_rx.in_frame <= 1'b1;
      set_cnt(13'h4);
      rd(8'h00, 32'h20, 32'h0);
      set_cnt(13'h5);
      rd(8'h00, 32'h20, 32'h20);
      bus(1'b1, 8'h04, 32'h1);
      set_cnt(13'h3);
      chk({31'h0, o_upload_ok}, 32'h0);
      set_cnt(13'h4);
      chk({31'h0, o_upload_ok}, 32'h1);
      @(posedge i_mclk);
      i_rx.in_frame <= 1'b0;
      // Halt before touching the list, then wait for pending to drop
      cmd(16'h3000);
      @(negedge i_mclk);
      chk({31'h0, o_fetch_halt}, 32'h1);
      rd(8'h00, 32'h1000, 32'h1000);
      for (int k = 0; k < 40 && q[12] !== 1'b0; k++) bus(1'b0, 8'h00, 32'h0);
      chk(q & 32'h1000, 32'h0);
      cmd(16'h3001);
      @(negedge i_mclk);
      chk({31'h0, o_fetch_halt}, 32'h0);
      // Busy descriptor seen twice, then cleared by software
      bus(1'b1, 8'h08, 32'h3);
      @(posedge i_mclk);
      busy <= 1'b1;
      rel = 1'b0;
      reads = 0;
      for (int k = 0; k < 300 && !rel; k++) begin
         @(negedge i_mclk);
         if (o_poll_read === 1'b1) reads++;
         if (o_desc_release === 1'b1) rel = 1'b1;
      end
      @(posedge i_mclk);
      busy <= 1'b0;
      chk({31'h0, rel}, 32'h1);
      chk(reads, 32'h3);
      report_and_stop();
   end
endmodule
`default_nettype wire
